/* design/vts_pkg.sv */
package vts_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_TRIP,
        ST_BLOCKED
    } vts_state_type;

    typedef struct packed {
        logic [3:0][1:0]  volt;
        logic [2:0]       sys;
        logic [3:0][15:0] ang;
        logic [2:0]       grp;
    } vts_meas_type;

    typedef struct packed {
        logic [2:0]  code;
        logic        on;
        logic [31:0] stamp;
    } vts_evt_type;

    typedef struct packed {
        logic [31:0]  stamp;
        logic [2:0]   code;
        logic [19:0]  rem;
        vts_meas_type meas;
    } vts_rec_type;

endpackage

/* design/vts_regs.svh */
`ifndef VTS_REGS_SVH
`define VTS_REGS_SVH

// register byte offsets
`define VTS_OFF_DELAY  8'h00
`define VTS_OFF_EVSEL  8'h04
`define VTS_OFF_CLR    8'h08
`define VTS_OFF_STAT   8'h0c
`define VTS_OFF_CNT0   8'h10
`define VTS_OFF_CNT3   8'h1c
`define VTS_OFF_RSEL   8'h20
`define VTS_OFF_RTIME  8'h24
`define VTS_OFF_RINFO  8'h28
`define VTS_OFF_RREM   8'h2c
`define VTS_OFF_RANG0  8'h30
`define VTS_OFF_RANG1  8'h34

// reset values
`define VTS_RST_DELAY  20'h000c8
`define VTS_RST_EVSEL  12'hfff

// record ring
`define VTS_REC_DEPTH  4'hc
`define VTS_REC_LAST   4'hb

// event source indices
`define VTS_SRC_START  3'h0
`define VTS_SRC_TRIP   3'h1
`define VTS_SRC_BLOCK  3'h2
`define VTS_SRC_LINE   3'h3
`define VTS_SRC_BFUSE  3'h4
`define VTS_SRC_LFUSE  3'h5

// per input voltage status codes
`define VTS_VOLT_NONE  2'h0
`define VTS_VOLT_OK    2'h1
`define VTS_VOLT_LOW   2'h2

// system status codes
`define VTS_SYS_DEAD   3'h0
`define VTS_SYS_OK     3'h1
`define VTS_SYS_REV    3'h2
`define VTS_SYS_UNDEF  3'h3
`define VTS_SYS_FAULT  3'h4

`endif

/* design/vts_supervision.sv */
// Function
// - sample blocking input once per cycle
// - pick-up unblocked asserts start, starts timing
// - pick-up while blocked asserts blocked only
// - blocking clears active start, releases timing
// - definite time delay from start to trip
// - per source ON/OFF event selection
// - time stamp on every event
// - clearable start, trip, line, blocked counters
// - ON/OFF events for six conditions
// - ring keeps twelve latest records
// - records written on ON events only
// - record has time, event, voltage states
// - record holds five-valued system status
// - record holds remaining time to operate
// - record holds angles and setting group
// - pick-up: one low or two high
// - small angle shift suppresses pick-up
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "vts_regs.svh"

module vts_supervision (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // apb slave
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // processing cycle and measurements
    input  wire logic                 cycle_tick,
    input  wire logic                 block_in,
    input  wire logic [2:0]           volt_low,
    input  wire logic [2:0]           volt_high,
    input  wire logic                 angle_shift_small,
    input  wire logic                 line_fail,
    input  wire logic                 bus_fuse_fail,
    input  wire logic                 line_fuse_fail,
    input  wire logic [31:0]          time_ms,
    input  wire vts_pkg::vts_meas_type meas,
    // status and events
    output logic                      start,
    output logic                      blocked,
    output logic                      trip,
    output logic                      event_valid,
    output vts_pkg::vts_evt_type      event_out
);
    vts_pkg::vts_state_type state_r, state_nxt;
    logic [19:0]  cnt_r, cnt_nxt, delay_r, delay_nxt, remain;
    logic         blk_r, blk_nxt, pu_r, pu_nxt, act_r, act_nxt, pickup, hi2;
    logic [5:0]   stat, prev_r, rise, fall;
    logic [11:0]  pend_r, pend_nxt, served, evsel_r, evsel_nxt;
    logic         ev_vld_nxt, rec_we, found;
    vts_pkg::vts_evt_type ev_nxt;
    logic [3:0][15:0] ctr_r, ctr_nxt;
    logic [3:0]   ctr_inc, clr;
    vts_pkg::vts_rec_type rec_mem [0:11];
    logic [3:0]   wr_ptr_r, wr_ptr_nxt, rec_cnt_r, rec_cnt_nxt, rsel_r, rsel_nxt;
    logic [31:0]  rdata_nxt;
    logic         err_nxt, wr_en;
    vts_pkg::vts_rec_type rsel_rec;
    // pick-up from the external comparators
    assign hi2    = (volt_high[0] & volt_high[1]) | (volt_high[0] & volt_high[2])
                  | (volt_high[1] & volt_high[2]);
    assign pickup = ((|volt_low) | hi2) & ~angle_shift_small;
    // decisions act one clock after the sample, always on the sampled pair
    always_comb begin
        blk_nxt   = blk_r;
        pu_nxt    = pu_r;
        act_nxt   = cycle_tick;
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (cycle_tick) begin
            blk_nxt = block_in;
            pu_nxt  = pickup;
        end
        if (act_r) begin
            case (state_r)
                vts_pkg::ST_IDLE: begin
                    cnt_nxt = 20'h0;
                    if (pu_r && !blk_r) begin
                        state_nxt = vts_pkg::ST_START;
                    end else if (pu_r) begin
                        state_nxt = vts_pkg::ST_BLOCKED;
                    end
                end
                vts_pkg::ST_START: begin
                    if (!pu_r || blk_r) begin
                        state_nxt = vts_pkg::ST_IDLE;
                        cnt_nxt   = 20'h0;
                    end else begin
                        cnt_nxt = cnt_r + 20'h1;
                        if (cnt_r + 20'h1 >= delay_r) begin
                            state_nxt = vts_pkg::ST_TRIP;
                        end
                    end
                end
                vts_pkg::ST_TRIP: begin
                    if (!pu_r || blk_r) begin
                        state_nxt = vts_pkg::ST_IDLE;
                        cnt_nxt   = 20'h0;
                    end
                end
                vts_pkg::ST_BLOCKED: begin
                    // block release re-arms through idle, so start is re-judged next cycle
                    if (!pu_r || !blk_r) begin
                        state_nxt = vts_pkg::ST_IDLE;
                    end
                end
                default: state_nxt = vts_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= vts_pkg::ST_IDLE;
            cnt_r   <= 20'h0;
            blk_r   <= 1'b0;
            pu_r    <= 1'b0;
            act_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            blk_r   <= blk_nxt;
            pu_r    <= pu_nxt;
            act_r   <= act_nxt;
        end
    end

    assign start   = (state_r == vts_pkg::ST_START) || (state_r == vts_pkg::ST_TRIP);
    assign trip    = (state_r == vts_pkg::ST_TRIP);
    assign blocked = (state_r == vts_pkg::ST_BLOCKED);
    assign remain  = (state_r == vts_pkg::ST_START) ? delay_r - cnt_r : 20'h0;
    // event detection and serialisation, one event per clock
    assign stat = {line_fuse_fail, bus_fuse_fail, line_fail, blocked, trip, start};
    assign rise = stat & ~prev_r;
    assign fall = ~stat & prev_r;

    always_comb begin
        found      = 1'b0;
        served     = 12'h0;
        ev_nxt     = '0;
        for (int j = 0; j < 12; j++) begin
            if (!found && pend_r[j]) begin
                found     = 1'b1;
                served[j] = 1'b1;
                ev_nxt.on = (j < 6);
                ev_nxt.code = (j < 6) ? 3'(j) : 3'(j - 6);
            end
        end
        ev_nxt.stamp = time_ms;
        ev_vld_nxt   = found && |(served & evsel_r);
        rec_we       = found && ev_nxt.on;
        // a new edge on a source being served is kept
        pend_nxt     = (pend_r & ~served) | {fall, rise};
    end
    // record ring
    always_comb begin
        wr_ptr_nxt  = wr_ptr_r;
        rec_cnt_nxt = rec_cnt_r;
        if (rec_we) begin
            wr_ptr_nxt = (wr_ptr_r == `VTS_REC_LAST) ? 4'h0 : wr_ptr_r + 4'h1;
            if (rec_cnt_r != `VTS_REC_DEPTH) begin
                rec_cnt_nxt = rec_cnt_r + 4'h1;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (rec_we) begin
            rec_mem[wr_ptr_r] <= '{stamp: time_ms, code: ev_nxt.code, rem: remain,
                                   meas: meas};
        end
    end
    // cumulative counters; a count in the clearing cycle survives
    assign ctr_inc = {rise[`VTS_SRC_BLOCK], rise[`VTS_SRC_LINE], rise[`VTS_SRC_TRIP],
                      rise[`VTS_SRC_START]};
    assign wr_en   = psel && penable && pwrite;
    assign clr     = (wr_en && paddr == `VTS_OFF_CLR) ? pwdata[3:0] : 4'h0;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            ctr_nxt[k] = clr[k] ? 16'(ctr_inc[k]) : ctr_r[k] + 16'(ctr_inc[k]);
        end
    end

    // apb: read data captured in the setup phase, no wait states
    assign rsel_rec = (rsel_r < `VTS_REC_DEPTH) ? rec_mem[rsel_r] : '0;
    always_comb begin
        delay_nxt = delay_r;
        evsel_nxt = evsel_r;
        rsel_nxt  = rsel_r;
        rdata_nxt = prdata;
        err_nxt   = pslverr;
        if (wr_en) begin
            if (paddr == `VTS_OFF_DELAY) begin
                delay_nxt = pwdata[19:0];
            end else if (paddr == `VTS_OFF_EVSEL) begin
                evsel_nxt = pwdata[11:0];
            end else if (paddr == `VTS_OFF_RSEL) begin
                rsel_nxt = pwdata[3:0];
            end
        end
        if (psel && !penable) begin
            err_nxt   = 1'b0;
            rdata_nxt = 32'h0;
            if (paddr == `VTS_OFF_DELAY) begin
                rdata_nxt = {12'h0, delay_r};
            end else if (paddr == `VTS_OFF_EVSEL) begin
                rdata_nxt = {20'h0, evsel_r};
            end else if (paddr == `VTS_OFF_STAT) begin
                rdata_nxt = {20'h0, rec_cnt_r, wr_ptr_r, 1'b0, blocked, trip, start};
            end else if (paddr >= `VTS_OFF_CNT0 && paddr <= `VTS_OFF_CNT3
                         && paddr[1:0] == 2'h0) begin
                rdata_nxt = {16'h0, ctr_r[paddr[3:2]]};
            end else if (paddr == `VTS_OFF_RSEL) begin
                rdata_nxt = {28'h0, rsel_r};
            end else if (paddr == `VTS_OFF_RTIME) begin
                rdata_nxt = rsel_rec.stamp;
            end else if (paddr == `VTS_OFF_RINFO) begin
                rdata_nxt = {rsel_rec.code, rsel_rec.meas.sys, rsel_rec.meas.grp, 15'h0,
                             rsel_rec.meas.volt};
            end else if (paddr == `VTS_OFF_RREM) begin
                rdata_nxt = {12'h0, rsel_rec.rem};
            end else if (paddr == `VTS_OFF_RANG0) begin
                rdata_nxt = {rsel_rec.meas.ang[1], rsel_rec.meas.ang[0]};
            end else if (paddr == `VTS_OFF_RANG1) begin
                rdata_nxt = {rsel_rec.meas.ang[3], rsel_rec.meas.ang[2]};
            end else begin
                err_nxt = (paddr != `VTS_OFF_CLR);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prev_r      <= 6'h0;
            pend_r      <= 12'h0;
            event_valid <= 1'b0;
            event_out   <= '0;
            wr_ptr_r    <= 4'h0;
            rec_cnt_r   <= 4'h0;
            ctr_r       <= '0;
            delay_r     <= `VTS_RST_DELAY;
            evsel_r     <= `VTS_RST_EVSEL;
            rsel_r      <= 4'h0;
            prdata      <= 32'h0;
            pslverr     <= 1'b0;
        end else begin
            prev_r      <= stat;
            pend_r      <= pend_nxt;
            event_valid <= ev_vld_nxt;
            event_out   <= ev_nxt;
            wr_ptr_r    <= wr_ptr_nxt;
            rec_cnt_r   <= rec_cnt_nxt;
            ctr_r       <= ctr_nxt;
            delay_r     <= delay_nxt;
            evsel_r     <= evsel_nxt;
            rsel_r      <= rsel_nxt;
            prdata      <= rdata_nxt;
            pslverr     <= err_nxt;
        end
    end

    assign pready = 1'b1;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_blk_sample;
        cycle_tick |=> blk_r == $past(block_in);
    endproperty
    a_blk_sample: assert property (p_blk_sample) else $error("block not sampled");
    property p_start;
        act_r && state_r == vts_pkg::ST_IDLE && pu_r && !blk_r |=> start && !blocked;
    endproperty
    a_start: assert property (p_start) else $error("start missing");
    property p_blocked;
        act_r && state_r == vts_pkg::ST_IDLE && pu_r && blk_r |=> blocked && !start;
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked missing");
    property p_release;
        act_r && start && blk_r |=> !start && cnt_r == 20'h0;
    endproperty
    a_release: assert property (p_release) else $error("start not released");
    property p_dt;
        act_r && state_r == vts_pkg::ST_START && pu_r && !blk_r
            && (cnt_r + 20'h1 >= delay_r) |=> trip;
    endproperty
    a_dt: assert property (p_dt) else $error("trip late");
    property p_count;
        act_r && state_r == vts_pkg::ST_START && pu_r && !blk_r |=> cnt_r == $past(cnt_r) + 20'h1;
    endproperty
    a_count: assert property (p_count) else $error("delay count wrong");
    property p_no_trip_early;
        trip && !$past(trip) |-> $past(cnt_r) + 20'h1 >= delay_r;
    endproperty
    a_no_trip_early: assert property (p_no_trip_early) else $error("trip early");
    property p_stamp;
        event_valid |-> event_out.stamp == $past(time_ms);
    endproperty
    a_stamp: assert property (p_stamp) else $error("bad time stamp");
    property p_evsel;
        event_valid |-> evsel_r[event_out.on ? int'(event_out.code) : int'(event_out.code) + 6];
    endproperty
    a_evsel: assert property (p_evsel) else $error("unselected event");
    property p_ctr;
        rise[`VTS_SRC_START] && !clr[0] |=> ctr_r[0] == $past(ctr_r[0]) + 16'h1;
    endproperty
    a_ctr: assert property (p_ctr) else $error("start counter");
    property p_rise_event;
        rise[`VTS_SRC_TRIP] |=> pend_r[`VTS_SRC_TRIP];
    endproperty
    a_rise_event: assert property (p_rise_event) else $error("edge lost");
    property p_ring;
        rec_we && wr_ptr_r == `VTS_REC_LAST |=> wr_ptr_r == 4'h0 && rec_cnt_r <= 4'hc;
    endproperty
    a_ring: assert property (p_ring) else $error("ring wrap");
    property p_pickup;
        cycle_tick && angle_shift_small |=> !pu_r;
    endproperty
    a_pickup: assert property (p_pickup) else $error("angle not suppressing");

    c_trip:    cover property (act_r ##1 trip);
    c_blocked: cover property (blocked ##1 !blocked);
    c_wrap:    cover property (rec_we && rec_cnt_r == `VTS_REC_DEPTH);
    c_release: cover property (start && blk_r && act_r);
endmodule

/* dv/vts_partner.sv */
`timescale 1ns/1ps

// blocking matrix and event recorder standing at the far side of the block
module vts_partner #(
    parameter int TICK_PERIOD = 4
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // blocking matrix
    input  wire logic                 block_req,
    output logic                      cycle_tick,
    output logic                      block_in,
    // event recorder
    input  wire logic                 event_valid,
    input  wire vts_pkg::vts_evt_type event_out
);
    vts_pkg::vts_evt_type evq[$];
    int                   div;

    // block level is only changed on a clock edge, so it is stable when a tick samples it
    always @(posedge core_clk) begin
        if (rst) begin
            div <= 0;
            cycle_tick <= 1'b0;
            block_in <= 1'b0;
        end else begin
            div <= (div == TICK_PERIOD - 1) ? 0 : div + 1;
            cycle_tick <= (div == TICK_PERIOD - 1);
            block_in <= block_req;
        end
        if (!rst && event_valid === 1'b1) begin
            evq.push_back(event_out);
        end
    end
endmodule

/* dv/vts_supervision_tb_top.sv */
`timescale 1ns/1ps
`include "vts_regs.svh"

module vts_supervision_tb_top;
    logic                  core_clk, rst, psel, penable, pwrite, block_req, er;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, time_ms, rd;
    logic                  pready, pslverr, cycle_tick, block_in, angle_shift_small;
    logic [2:0]            volt_low, volt_high, st;
    logic                  line_fail, bus_fuse_fail, line_fuse_fail;
    logic                  start, blocked, trip, event_valid;
    vts_pkg::vts_meas_type meas;
    vts_pkg::vts_evt_type  event_out;
    int                    errors, n_compared;

    assign st = {blocked, trip, start};

    vts_supervision vts_supervision_i (.core_clk(core_clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cycle_tick(cycle_tick), .block_in(block_in),
        .volt_low(volt_low), .volt_high(volt_high), .angle_shift_small(angle_shift_small),
        .line_fail(line_fail), .bus_fuse_fail(bus_fuse_fail),
        .line_fuse_fail(line_fuse_fail), .time_ms(time_ms), .meas(meas), .start(start),
        .blocked(blocked), .trip(trip), .event_valid(event_valid), .event_out(event_out));

    vts_partner vts_partner_i (.core_clk(core_clk), .rst(rst), .block_req(block_req),
        .cycle_tick(cycle_tick), .block_in(block_in), .event_valid(event_valid),
        .event_out(event_out));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task report_and_stop;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task cmp_evt(input vts_pkg::vts_evt_type got, input logic [2:0] code, input logic on);
        n_compared++;
        if (got !== {code, on, time_ms}) begin
            errors++;
            $display("mismatch at %0t: event %h code %h on %b", $time, got, code, on);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp_word(rd, exp);
    endtask

    // bounded wait for one of start, trip, blocked to reach a level
    task automatic wait_out(input int k, input logic v);
        int i;
        for (i = 0; i < 200 && st[k] !== v; i++) begin
            @(posedge core_clk);
        end
        #1;
    endtask

    task t_reset;
        rd_chk(`VTS_OFF_DELAY, 32'h000000c8);
        rd_chk(`VTS_OFF_EVSEL, 32'h00000fff);
        rd_chk(`VTS_OFF_STAT, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        cmp_word({31'h0, er}, 32'h1);
        cmp_word(rd, 32'h0);
    endtask

    task automatic t_trip;
        int n;
        apb(1'b1, `VTS_OFF_DELAY, 32'h5);
        vts_partner_i.evq.delete();
        volt_low <= 3'b001;
        wait_out(0, 1'b1);
        cmp_word({29'h0, st}, 32'h1);
        n = 0;
        for (int i = 0; i < 200 && trip !== 1'b1; i++) begin
            @(posedge core_clk);
            n += (cycle_tick === 1'b1);
        end
        cmp_word({31'h0, n inside {[4:6]}}, 32'h1);
        repeat (6) @(posedge core_clk);
        cmp_evt(vts_partner_i.evq[0], `VTS_SRC_START, 1'b1);
        cmp_evt(vts_partner_i.evq[1], `VTS_SRC_TRIP, 1'b1);
        block_req <= 1'b1;
        wait_out(0, 1'b0);
        cmp_word({31'h0, trip}, 32'h0);
        wait_out(2, 1'b1);
        cmp_word({29'h0, st}, 32'h4);
        rd_chk(`VTS_OFF_CNT0, 32'h1);
        rd_chk(`VTS_OFF_CNT0 + 8'h4, 32'h1);
        rd_chk(`VTS_OFF_CNT3, 32'h1);
        // slot 0 holds the start record, taken before the first delay tick
        apb(1'b1, `VTS_OFF_RSEL, 32'h0);
        rd_chk(`VTS_OFF_RREM, 32'h5);
        volt_low <= 3'b000;
        block_req <= 1'b0;
        wait_out(2, 1'b0);
    endtask

    task t_suppress;
        block_req <= 1'b1;
        repeat (10) @(posedge core_clk);
        volt_high <= 3'b101;
        wait_out(2, 1'b1);
        cmp_word({29'h0, st}, 32'h4);
        volt_high <= 3'b000;
        block_req <= 1'b0;
        wait_out(2, 1'b0);
        volt_high <= 3'b100;
        repeat (20) @(posedge core_clk);
        cmp_word({29'h0, st}, 32'h0);
        angle_shift_small <= 1'b1;
        volt_high <= 3'b110;
        repeat (20) @(posedge core_clk);
        cmp_word({29'h0, st}, 32'h0);
        angle_shift_small <= 1'b0;
        wait_out(0, 1'b1);
        cmp_word({29'h0, st}, 32'h1);
        volt_high <= 3'b000;
        wait_out(0, 1'b0);
    endtask

    task t_evsel;
        logic [31:0] mask [3] = '{32'h020, 32'h800, 32'h820};
        logic [31:0] num [3] = '{32'h1, 32'h1, 32'h2};
        logic        first_on [3] = '{1'b1, 1'b0, 1'b1};
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `VTS_OFF_EVSEL, mask[k]);
            vts_partner_i.evq.delete();
            line_fuse_fail <= 1'b1;
            repeat (8) @(posedge core_clk);
            line_fuse_fail <= 1'b0;
            repeat (8) @(posedge core_clk);
            cmp_word(vts_partner_i.evq.size(), num[k]);
            cmp_evt(vts_partner_i.evq[0], `VTS_SRC_LFUSE, first_on[k]);
        end
        apb(1'b1, `VTS_OFF_EVSEL, 32'hfff);
    endtask

    task automatic t_ring;
        logic [3:0] p0;
        logic [3:0] p1;
        time_ms <= 32'h00020000;
        apb(1'b0, `VTS_OFF_STAT, 32'h0);
        p0 = rd[7:4];
        repeat (13) begin
            bus_fuse_fail <= 1'b1;
            repeat (6) @(posedge core_clk);
            bus_fuse_fail <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
        apb(1'b0, `VTS_OFF_STAT, 32'h0);
        p1 = 4'((p0 + 13) % 12);
        cmp_word({28'h0, rd[11:8]}, 32'hc);
        cmp_word({28'h0, rd[7:4]}, {28'h0, p1});
        apb(1'b1, `VTS_OFF_RSEL, {28'h0, 4'((p1 + 11) % 12)});
        rd_chk(`VTS_OFF_RTIME, time_ms);
        apb(1'b0, `VTS_OFF_RINFO, 32'h0);
        cmp_word(rd & 32'hff8000ff,
                 {`VTS_SRC_BFUSE, meas.sys, meas.grp, 15'h0, meas.volt});
        rd_chk(`VTS_OFF_RREM, 32'h0);
        rd_chk(`VTS_OFF_RANG0, {meas.ang[1], meas.ang[0]});
        rd_chk(`VTS_OFF_RANG1, {meas.ang[3], meas.ang[2]});
    endtask

    task t_counters;
        apb(1'b1, `VTS_OFF_CLR, 32'hf);
        for (int k = 0; k < 4; k++) begin
            rd_chk(`VTS_OFF_CNT0 + 8'(4 * k), 32'h0);
        end
        line_fail <= 1'b1;
        repeat (8) @(posedge core_clk);
        line_fail <= 1'b0;
        rd_chk(`VTS_OFF_CNT0 + 8'h8, 32'h1);
        rd_chk(`VTS_OFF_CNT0, 32'h0);
    endtask

    initial begin
        {psel, penable, pwrite, block_req, angle_shift_small} = 5'h0;
        {line_fail, bus_fuse_fail, line_fuse_fail} = 3'h0;
        {paddr, pwdata, volt_low, volt_high} = 46'h0;
        {errors, n_compared} = 64'h0;
        time_ms = 32'h00012345;
        meas.volt = {`VTS_VOLT_LOW, `VTS_VOLT_OK, `VTS_VOLT_NONE, `VTS_VOLT_OK};
        meas.sys = `VTS_SYS_REV;
        meas.ang = {16'h8ca0, 16'h0001, 16'h1234, 16'h0fa0};
        meas.grp = 3'h5;
        rst = 1'b1;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_trip();
        t_suppress();
        t_evsel();
        t_ring();
        t_counters();
        report_and_stop();
    end

    // the sequence needs a few hundred cycles; a hang is cut well past that
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end
endmodule
